// ==== uart_pins_map.vh ====
// Behaviour
// - Module on forces transmit pin output
// - Module on forces receive pin input
// - Loop mode feeds transmitter into receiver
// - Module enable; off sets empty, done
// - Inversion flips every transmitted level
// - Length bit selects nine or eight
// - Wakeup bit: address mark or idle
// - Idle count starts after stop/start
// - Parity bit in msb, sent, checked
// - Parity kind: odd when set, else even
// - One start, one stop; 10/11 bits
// - Empty flag requests only when enabled
// - Done flag requests only when enabled
// - Receive full requests only when enabled
// - Idle flag requests only when enabled
// - Transmit enable sends all-ones preamble first; a word or break already waiting at enable goes out before it
// - Disable finishes current character, then idle
// - Re-enable mid-character queues one idle character
// - Reset clears both control registers
// - Receive enable; reset clears it
// - Standby mutes receiver; wake condition clears
// - Break bit sends break characters, then one
`ifndef UART_PINS_MAP_VH
`define UART_PINS_MAP_VH

// Register byte addresses
`define ADDR_CTRL_ONE   4'h0
`define ADDR_CTRL_TWO   4'h4
`define ADDR_STATUS     4'h8
`define ADDR_DATA       4'hC

// Control one fields
`define C1_LOOP         7
`define C1_MODULE_ON    6
`define C1_TX_FLIP      5
`define C1_NINE_BIT     4
`define C1_WAKE_MARK    3
`define C1_IDLE_START   2
`define C1_PARITY_ON    1
`define C1_PARITY_KIND  0

// Control two fields
`define C2_TX_EMPTY_IE  7
`define C2_TX_DONE_IE   6
`define C2_RX_FULL_IE   5
`define C2_IDLE_IE      4
`define C2_TX_ON        3
`define C2_RX_ON        2
`define C2_STANDBY      1
`define C2_BREAK        0

// Status fields
`define ST_TX_EMPTY     7
`define ST_TX_DONE      6
`define ST_RX_FULL      5
`define ST_IDLE         4
`define ST_PARITY_ERR   0

// Reset values
`define CTRL_RESET      8'h00
`define DATA_RESET      9'h000

// Bit time in module clock cycles
`define BIT_CYCLES      16

// Bus responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ==== uart_pins_ctrl.v ====
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "uart_pins_map.vh"

module uart_pins_ctrl
#(
  parameter BIT_CYCLES = `BIT_CYCLES              // Cycles per bit time
)
(
  input  wire        aclk,                        // Module clock
  input  wire        aresetn,                     // Sync reset, low
  input  wire [3:0]  s_axi_awaddr,                // Write address
  input  wire        s_axi_awvalid,               // Write address valid
  output reg         s_axi_awready,               // Write address ready
  input  wire [31:0] s_axi_wdata,                 // Write data
  input  wire [3:0]  s_axi_wstrb,                 // Write strobes
  input  wire        s_axi_wvalid,                // Write data valid
  output reg         s_axi_wready,                // Write data ready
  output reg  [1:0]  s_axi_bresp,                 // Write response
  output reg         s_axi_bvalid,                // Write response valid
  input  wire        s_axi_bready,                // Write response ready
  input  wire [3:0]  s_axi_araddr,                // Read address
  input  wire        s_axi_arvalid,               // Read address valid
  output reg         s_axi_arready,               // Read address ready
  output reg  [31:0] s_axi_rdata,                 // Read data
  output reg  [1:0]  s_axi_rresp,                 // Read response
  output reg         s_axi_rvalid,                // Read data valid
  input  wire        s_axi_rready,                // Read data ready
  input  wire        tx_pin_dir_bit,              // Port direction, tx pin
  input  wire        rx_pin_dir_bit,              // Port direction, rx pin
  input  wire        port_tx_data,                // Port data, tx pin
  input  wire        port_rx_data,                // Port data, rx pin
  input  wire        shared_tx_pin_in,            // Tx pin level (unused)
  output reg         shared_tx_pin_out,           // Tx pin drive value
  output reg         shared_tx_pin_oe_n,          // Tx pin enable, low
  input  wire        shared_rx_pin_in,            // Rx pin level
  output reg         shared_rx_pin_out,           // Rx pin drive value
  output reg         shared_rx_pin_oe_n,          // Rx pin enable, low
  output reg         tx_irq,                      // Transmitter request
  output reg         rx_irq                       // Receiver request
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Builds an 11-bit frame, lsb first: start, data, ninth, stop
  function [10:0] build_frame;
    input [8:0] d;
    input       nine;
    input       p_on;
    input       p_odd;
    begin
      if (nine)
        build_frame = {1'b1, (p_on ? (^d[7:0]) ^ p_odd : d[8]), d[7:0], 1'b0};
      else
        build_frame = {2'b11, (p_on ? (^d[6:0]) ^ p_odd : d[7]), d[6:0], 1'b0};
    end
  endfunction

  // Frame length in bits
  function [3:0] frame_len;
    input nine;
    begin
      frame_len = nine ? 4'd11 : 4'd10;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  reg  [7:0]  ctrl_one_ff;                        // Control one
  reg  [7:0]  ctrl_two_ff;                        // Control two
  reg  [8:0]  tx_data_ff;                         // Transmit holding word
  reg  [8:0]  rx_data_ff;                         // Received word
  reg         tx_empty_ff;                        // Holding word moved
  reg         tx_done_ff;                         // Nothing being sent
  reg         rx_full_ff;                         // Received word ready
  reg         idle_flag_ff;                       // Idle line seen
  reg         par_err_ff;                         // Parity mismatch
  reg         seen_tx_ff;                         // Status read, empty set
  reg         seen_rx_ff;                         // Status read, full set
  reg         seen_idle_ff;                       // Status read, idle set

  wire module_on = ctrl_one_ff[`C1_MODULE_ON];
  wire nine_bit  = ctrl_one_ff[`C1_NINE_BIT];
  wire tx_on     = ctrl_two_ff[`C2_TX_ON];
  wire rx_on     = ctrl_two_ff[`C2_RX_ON];
  wire standby   = ctrl_two_ff[`C2_STANDBY];
  wire brk       = ctrl_two_ff[`C2_BREAK];
  wire [3:0] len = frame_len(nine_bit);

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data taken in either order

  reg         aw_held_ff;                         // Address latched
  reg         w_held_ff;                          // Data latched
  reg  [3:0]  aw_addr_ff;                         // Latched address
  reg  [31:0] w_data_ff;                          // Latched data
  reg         w_lane0_ff;                         // Low byte strobe

  wire wr_go = aw_held_ff && w_held_ff && !s_axi_bvalid;
  wire wr_ok = aw_addr_ff == `ADDR_CTRL_ONE || aw_addr_ff == `ADDR_CTRL_TWO ||
               aw_addr_ff == `ADDR_DATA;
  wire wr_en = wr_go && wr_ok && w_lane0_ff;
  wire wr_c1 = wr_en && aw_addr_ff == `ADDR_CTRL_ONE;
  wire wr_c2 = wr_en && aw_addr_ff == `ADDR_CTRL_TWO;
  wire wr_dt = wr_en && aw_addr_ff == `ADDR_DATA;

  // Channel handshakes and write response
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_ff    <= 1'b0;
      w_held_ff     <= 1'b0;
      aw_addr_ff    <= 4'h0;
      w_data_ff     <= 32'h00000000;
      w_lane0_ff    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end
    else
    begin
      // Ready is offered only while the slot is empty
      s_axi_awready <= !aw_held_ff && !s_axi_bvalid &&
                       !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held_ff && !s_axi_bvalid &&
                       !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= {s_axi_awaddr[3:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_ff  <= 1'b1;
        w_data_ff  <= s_axi_wdata;
        w_lane0_ff <= s_axi_wstrb[0];
      end
      if (wr_go)
      begin
        aw_held_ff   <= 1'b0;
        w_held_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel: answer one cycle after the address is taken

  wire rd_go = s_axi_arvalid && s_axi_arready;
  wire [3:0] rd_addr = {s_axi_araddr[3:2], 2'b00};
  wire rd_st = rd_go && rd_addr == `ADDR_STATUS;
  wire rd_dt = rd_go && rd_addr == `ADDR_DATA;
  wire [7:0] status_word = {tx_empty_ff, tx_done_ff, rx_full_ff,
                            idle_flag_ff, 3'b000, par_err_ff};

  // Read data mux and handshake
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !rd_go;
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        case (rd_addr)
          `ADDR_CTRL_ONE: s_axi_rdata <= {24'h000000, ctrl_one_ff};
          `ADDR_CTRL_TWO: s_axi_rdata <= {24'h000000, ctrl_two_ff};
          `ADDR_STATUS:   s_axi_rdata <= {24'h000000, status_word};
          `ADDR_DATA:     s_axi_rdata <= {23'h000000, rx_data_ff};
          default:
          begin
            // Unmapped address reads zero with an error
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter

  reg         tx_busy_ff;                         // Frame shifting out
  reg  [15:0] tx_cnt_ff;                          // Cycles left in bit
  reg  [3:0]  tx_left_ff;                         // Bits left in frame
  reg  [10:0] tx_sh_ff;                           // Frame shifter
  reg         tx_on_prev_ff;                      // Enable last cycle
  reg         pre_pend_ff;                        // Preamble queued
  reg         brk_sent_ff;                        // Break went out

  wire tx_line = tx_busy_ff ? tx_sh_ff[0] : 1'b1;
  wire bit_end = tx_busy_ff && tx_cnt_ff == 16'd0;
  wire tx_free = !tx_busy_ff || (bit_end && tx_left_ff == 4'd1);

  // Frame loading, shifting and transmit flags
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_busy_ff    <= 1'b0;
      tx_cnt_ff     <= 16'h0000;
      tx_left_ff    <= 4'h0;
      tx_sh_ff      <= 11'h7FF;
      tx_on_prev_ff <= 1'b0;
      pre_pend_ff   <= 1'b0;
      brk_sent_ff   <= 1'b0;
      tx_empty_ff   <= 1'b1;
      tx_done_ff    <= 1'b1;
      tx_data_ff    <= `DATA_RESET;
    end
    else
    begin
      tx_on_prev_ff <= tx_on;
      // A rising enable, even mid-frame, queues one all-ones frame
      if (tx_on && !tx_on_prev_ff)
        pre_pend_ff <= 1'b1;
      if (bit_end)
      begin
        tx_cnt_ff  <= BIT_CYCLES[15:0] - 16'd1;
        tx_left_ff <= tx_left_ff - 4'd1;
        tx_sh_ff   <= {1'b1, tx_sh_ff[10:1]};
        if (tx_left_ff == 4'd1)
          tx_busy_ff <= 1'b0;
      end
      else if (tx_busy_ff)
        tx_cnt_ff <= tx_cnt_ff - 16'd1;
      // The frame in flight always finishes; new frames need enable
      if (tx_free && tx_on && module_on)
      begin
        if (pre_pend_ff)
        begin
          tx_busy_ff  <= 1'b1;
          tx_cnt_ff   <= BIT_CYCLES[15:0] - 16'd1;
          tx_left_ff  <= len;
          tx_sh_ff    <= 11'h7FF;
          pre_pend_ff <= 1'b0;
        end
        else if (brk)
        begin
          tx_busy_ff  <= 1'b1;
          tx_cnt_ff   <= BIT_CYCLES[15:0] - 16'd1;
          tx_left_ff  <= len;
          tx_sh_ff    <= 11'h000;
          brk_sent_ff <= 1'b1;
        end
        else if (brk_sent_ff)
        begin
          // Single marking bit after the last break character
          tx_busy_ff  <= 1'b1;
          tx_cnt_ff   <= BIT_CYCLES[15:0] - 16'd1;
          tx_left_ff  <= 4'd1;
          tx_sh_ff    <= 11'h7FF;
          brk_sent_ff <= 1'b0;
        end
        else if (!tx_empty_ff)
        begin
          tx_busy_ff  <= 1'b1;
          tx_cnt_ff   <= BIT_CYCLES[15:0] - 16'd1;
          tx_left_ff  <= len;
          tx_sh_ff    <= build_frame(tx_data_ff, nine_bit,
                           ctrl_one_ff[`C1_PARITY_ON],
                           ctrl_one_ff[`C1_PARITY_KIND]);
          tx_empty_ff <= 1'b1;
        end
      end
      // Software fills the holding word after seeing it empty
      if (wr_dt)
      begin
        tx_data_ff <= w_data_ff[8:0];
        if (seen_tx_ff)
          tx_empty_ff <= 1'b0;
      end
      tx_done_ff <= tx_empty_ff && !tx_busy_ff && !pre_pend_ff &&
                    !brk && !brk_sent_ff;
      // Switching the module off forces both flags
      if (!module_on)
      begin
        tx_empty_ff <= 1'b1;
        tx_done_ff  <= 1'b1;
        pre_pend_ff <= 1'b0;
        brk_sent_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver

  reg         rx_busy_ff;                         // Frame coming in
  reg  [15:0] rx_cnt_ff;                          // Cycles to next sample
  reg  [3:0]  rx_idx_ff;                          // Bit index in frame
  reg  [10:0] rx_sh_ff;                           // Sampled bits
  reg         rx_prev_ff;                         // Line last cycle
  reg  [19:0] idle_cyc_ff;                        // High line cycles
  reg         idle_hit_ff;                        // Idle already counted
  reg         idle_arm_ff;                        // Full seen since idle

  // Loop mode cuts the pin and feeds the transmitter back in
  wire rx_line = ctrl_one_ff[`C1_LOOP] ?
                 (tx_line ^ ctrl_one_ff[`C1_TX_FLIP]) : shared_rx_pin_in;
  wire rx_act  = module_on && rx_on;
  wire sample  = rx_busy_ff && rx_cnt_ff == 16'd0;
  wire last    = rx_idx_ff == len - 4'd1;
  wire [8:0] rx_word = nine_bit ? rx_sh_ff[9:1] : {1'b0, rx_sh_ff[8:1]};
  wire rx_msb  = nine_bit ? rx_sh_ff[9] : rx_sh_ff[8];
  wire par_bad = ctrl_one_ff[`C1_PARITY_ON] &&
                 ((^rx_word) != ctrl_one_ff[`C1_PARITY_KIND]);
  wire frame_in = sample && last;
  wire [19:0] idle_need = len * BIT_CYCLES[15:0];
  wire idle_now = rx_act && !idle_hit_ff && idle_cyc_ff >= idle_need;

  // Sampling, wakeup and receive flags
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_busy_ff   <= 1'b0;
      rx_cnt_ff    <= 16'h0000;
      rx_idx_ff    <= 4'h0;
      rx_sh_ff     <= 11'h000;
      rx_prev_ff   <= 1'b1;
      rx_data_ff   <= `DATA_RESET;
      rx_full_ff   <= 1'b0;
      idle_flag_ff <= 1'b0;
      par_err_ff   <= 1'b0;
      idle_cyc_ff  <= 20'h00000;
      idle_hit_ff  <= 1'b0;
      idle_arm_ff  <= 1'b0;
    end
    else
    begin
      rx_prev_ff <= rx_line;
      // Falling edge starts a frame, sampled mid-bit
      if (!rx_busy_ff && rx_act && rx_prev_ff && !rx_line)
      begin
        rx_busy_ff <= 1'b1;
        rx_idx_ff  <= 4'h0;
        rx_cnt_ff  <= BIT_CYCLES[15:0] / 16'd2;
      end
      else if (sample)
      begin
        rx_sh_ff[rx_idx_ff] <= rx_line;
        rx_cnt_ff <= BIT_CYCLES[15:0] - 16'd1;
        rx_idx_ff <= rx_idx_ff + 4'd1;
        if ((rx_idx_ff == 4'd0 && rx_line) || last || !rx_act)
          rx_busy_ff <= 1'b0;
      end
      else if (rx_busy_ff)
        rx_cnt_ff <= rx_cnt_ff - 16'd1;
      // Idle counting: line low or, if chosen, a frame holds it
      if (!rx_line || (ctrl_one_ff[`C1_IDLE_START] && rx_busy_ff))
      begin
        idle_cyc_ff <= 20'h00000;
        idle_hit_ff <= 1'b0;
      end
      else if (idle_cyc_ff < idle_need)
        idle_cyc_ff <= idle_cyc_ff + 20'h00001;
      if (idle_now)
        idle_hit_ff <= 1'b1;
      // Flag clears by status read then data read
      if (rd_dt && seen_rx_ff)
        rx_full_ff <= 1'b0;
      if (rd_dt && seen_idle_ff)
        idle_flag_ff <= 1'b0;
      // Hardware sets are placed last so they win over clears
      if (frame_in && rx_act && (!standby ||
          (ctrl_one_ff[`C1_WAKE_MARK] && rx_msb)))
      begin
        rx_data_ff  <= rx_word;
        rx_full_ff  <= 1'b1;
        par_err_ff  <= par_bad;
        idle_arm_ff <= 1'b1;
      end
      if (idle_now && idle_arm_ff && !standby)
      begin
        idle_flag_ff <= 1'b1;
        idle_arm_ff  <= 1'b0;
      end
      if (!rx_act)
        idle_arm_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers and flag-clear tracking

  // Transmit and receive enable bits are writable only while the module is on
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_one_ff  <= `CTRL_RESET;
      ctrl_two_ff  <= `CTRL_RESET;
      seen_tx_ff   <= 1'b0;
      seen_rx_ff   <= 1'b0;
      seen_idle_ff <= 1'b0;
    end
    else
    begin
      if (wr_c1)
        ctrl_one_ff <= w_data_ff[7:0];
      if (wr_c2)
      begin
        ctrl_two_ff <= w_data_ff[7:0];
        if (!module_on)
        begin
          ctrl_two_ff[`C2_TX_ON] <= tx_on;
          ctrl_two_ff[`C2_RX_ON] <= rx_on;
        end
      end
      // Wake condition ends standby
      if (standby && frame_in && ctrl_one_ff[`C1_WAKE_MARK] && rx_msb)
        ctrl_two_ff[`C2_STANDBY] <= 1'b0;
      if (standby && idle_now && !ctrl_one_ff[`C1_WAKE_MARK])
        ctrl_two_ff[`C2_STANDBY] <= 1'b0;
      if (rd_st)
      begin
        seen_tx_ff   <= tx_empty_ff;
        seen_rx_ff   <= rx_full_ff;
        seen_idle_ff <= idle_flag_ff;
      end
      else if (rd_dt)
      begin
        seen_rx_ff   <= 1'b0;
        seen_idle_ff <= 1'b0;
      end
      if (wr_dt)
        seen_tx_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin takeover and request outputs

  // Everything leaves through flops
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      shared_tx_pin_out  <= 1'b1;
      shared_tx_pin_oe_n <= 1'b1;
      shared_rx_pin_out  <= 1'b0;
      shared_rx_pin_oe_n <= 1'b1;
      tx_irq             <= 1'b0;
      rx_irq             <= 1'b0;
    end
    else
    begin
      if (module_on)
      begin
        shared_tx_pin_out  <= tx_line ^ ctrl_one_ff[`C1_TX_FLIP];
        shared_tx_pin_oe_n <= 1'b0;
        shared_rx_pin_out  <= 1'b0;
        shared_rx_pin_oe_n <= 1'b1;
      end
      else
      begin
        shared_tx_pin_out  <= port_tx_data;
        shared_tx_pin_oe_n <= !tx_pin_dir_bit;
        shared_rx_pin_out  <= port_rx_data;
        shared_rx_pin_oe_n <= !rx_pin_dir_bit;
      end
      tx_irq <= module_on &&
                ((tx_empty_ff && ctrl_two_ff[`C2_TX_EMPTY_IE]) ||
                 (tx_done_ff && ctrl_two_ff[`C2_TX_DONE_IE]));
      rx_irq <= !standby &&
                ((rx_full_ff && ctrl_two_ff[`C2_RX_FULL_IE]) ||
                 (idle_flag_ff && ctrl_two_ff[`C2_IDLE_IE]));
    end
  end

endmodule
`default_nettype wire

// ==== uart_pins_ctrl_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module uart_pins_checker
(
  input wire logic aclk,               // Clock
  input wire logic aresetn,            // Sync reset, low
  input wire logic s_axi_awready,      // Write address ready
  input wire logic s_axi_wready,       // Write data ready
  input wire logic s_axi_bvalid,       // Write answer
  input wire logic s_axi_arvalid,      // Read request
  input wire logic s_axi_arready,      // Read address ready
  input wire logic s_axi_rvalid,       // Read answer
  input wire logic tx_pin_dir_bit,     // Port direction, tx
  input wire logic rx_pin_dir_bit,     // Port direction, rx
  input wire logic shared_tx_pin_out,  // Tx drive value
  input wire logic shared_tx_pin_oe_n, // Tx enable, low
  input wire logic shared_rx_pin_oe_n, // Rx enable, low
  input wire logic tx_irq,             // Transmit request
  input wire logic rx_irq              // Receive request
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  // Pins and requests start released
  a_reset_quiet:
  assert property ($rose(aresetn) |-> !tx_irq && !rx_irq
    && shared_tx_pin_oe_n && shared_rx_pin_oe_n)
    else $error("outputs not cleared by reset");
  // A released tx pin means module off and port asks input
  a_tx_forced:
  assert property ($past(aresetn) && shared_tx_pin_oe_n
    |-> !$past(tx_pin_dir_bit)) else $error("tx pin not forced out");
  // A driven rx pin means module off and port asks output
  a_rx_forced:
  assert property ($past(aresetn) && !shared_rx_pin_oe_n
    |-> $past(rx_pin_dir_bit)) else $error("rx pin not forced in");
  // Both pins are taken over together
  a_pins_together:
  assert property ($past(aresetn) && shared_rx_pin_oe_n
    && $past(rx_pin_dir_bit) |-> !shared_tx_pin_oe_n)
    else $error("pins not taken over together");
  // Transmit requests are muted while the module is off
  a_irq_needs_on:
  assert property (tx_irq |-> !shared_tx_pin_oe_n)
    else $error("tx request while module off");
  // No new write accepted while answering; hazard of lost writes
  a_write_refused:
  assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  a_read_answer:
  assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_refused:
  assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during answer");
  c_tx_irq: cover property (tx_irq);
  c_rx_irq: cover property (rx_irq);
  c_tx_bit: cover property ($fell(shared_tx_pin_out) && !shared_tx_pin_oe_n);
endmodule
bind uart_pins_ctrl uart_pins_checker chk_i (.*);
`default_nettype wire

// ==== uart_remote.sv ====
`timescale 1ns/1ps
`default_nettype none
module uart_remote
#(
  parameter int BIT = 4                // Cycles per bit
)
(
  input  wire logic       aclk,        // Bit timing clock
  input  wire logic       rx_line,     // Line from the block
  input  wire logic       send,        // Starts one frame
  input  wire logic [7:0] send_byte,   // Byte to send
  output var  logic       tx_line,     // Line to the block
  output var  logic [7:0] got,         // Last byte taken
  output var  int         got_n        // Good frames taken
);
  initial tx_line = 1'b1;
  initial got_n = 0;
  // Sender: start, eight bits lsb first, stop; idles high
  always @(posedge send)
  begin
    for (int i = 0; i < 10; i++)
    begin
      tx_line <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : send_byte[i-1];
      repeat (BIT) @(posedge aclk);
    end
  end
  // Receiver starts only on a falling edge, so an all-ones preamble is not a frame
  always
  begin
    @(negedge rx_line);
    repeat (BIT / 2) @(posedge aclk);
    if (rx_line === 1'b0)
    begin
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT) @(posedge aclk);
        got[i] = rx_line;
      end
      repeat (BIT) @(posedge aclk);
      if (rx_line === 1'b1)
        got_n++;
    end
  end
endmodule
`default_nettype wire

// ==== uart_pins_and_control_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module uart_pins_and_control_regs_tb;
  localparam int BIT = 4;              // Short bit time keeps runs brief
  typedef struct {logic w; logic [3:0] a; logic [31:0] v, e; logic [1:0] re;}
    row_t;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic tx_pin_dir_bit = 1'b0, rx_pin_dir_bit = 1'b1, go = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, d;
  logic [7:0] byte_out = 8'h00, got;
  logic [1:0] r;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire shared_tx_pin_out, shared_tx_pin_oe_n, shared_rx_pin_out, tx_irq;
  wire shared_rx_pin_oe_n, rx_irq, far_line, tx_wire, rx_wire;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int n_mismatch = 0, cmp_count = 0, cyc = 0, k, got_n;
  row_t rows[6] = '{'{1, 4'h0, 32'h5F, 32'h5F, 2'h0},
    '{1, 4'h4, 32'hF3, 32'hF3, 2'h0}, '{1, 4'h4, 32'h0, 32'h0, 2'h0},
    '{1, 4'h0, 32'h0, 32'h0, 2'h0}, '{0, 4'h8, 32'h0, 32'hC0, 2'h0},
    '{1, 4'h8, 32'hFF, 32'hC0, 2'h2}};
  always #2.5 aclk = ~aclk;
  // The tx pin has a pull-up; a released rx pin follows the far end's line
  assign tx_wire = shared_tx_pin_oe_n ? 1'b1 : shared_tx_pin_out;
  assign rx_wire = shared_rx_pin_oe_n ? far_line : shared_rx_pin_out;
  uart_pins_ctrl #(.BIT_CYCLES(BIT)) dut (.*, .s_axi_wstrb(4'hF),
    .port_tx_data(1'b1), .port_rx_data(1'b0), .shared_tx_pin_in(tx_wire),
    .shared_rx_pin_in(rx_wire));
  uart_remote #(.BIT(BIT)) far (.aclk(aclk), .rx_line(tx_wire), .send(go),
    .send_byte(byte_out), .tx_line(far_line), .got(got), .got_n(got_n));
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  // Offers address and data together, drops each once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Cuts a hang short
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      final_report;
    end
  end
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i])
    begin
      if (rows[i].w) wr(rows[i].a, rows[i].v);
      if (rows[i].w) chk("write resp", rows[i].re, r);
      rd(rows[i].a);
      chk("read data", rows[i].e, d);
      chk("read resp", 2'h0, r);
    end
    $display("end of register rows");
    chk("tx pin released", 1'b1, shared_tx_pin_oe_n);
    wr(4'h0, 32'h40);
    repeat (2) @(posedge aclk);
    chk("tx pin driven", 1'b0, shared_tx_pin_oe_n);
    chk("rx pin input", 1'b1, shared_rx_pin_oe_n);
    tx_pin_dir_bit <= 1'b1;
    wr(4'h4, 32'h0C);
    wr(4'hC, 32'hA5);
    for (k = 0; tx_wire !== 1'b0 && k < 400; k++) @(posedge aclk);
    chk("preamble long", 1'b1, k > 9 * BIT);
    for (k = 0; got_n < 1 && k < 400; k++) @(posedge aclk);
    chk("byte sent", 32'hA5, got);
    $display("end of transmit");
    wr(4'h4, 32'hAC);
    repeat (2) @(posedge aclk);
    chk("empty request", 1'b1, tx_irq);
    chk("no rx request", 1'b0, rx_irq);
    byte_out <= 8'h3C;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    for (k = 0; rx_irq !== 1'b1 && k < 600; k++) @(posedge aclk);
    chk("full request", 1'b1, rx_irq);
    rd(4'hC);
    chk("byte taken", 32'h3C, d);
    wr(4'h4, 32'h0C);
    repeat (2) @(posedge aclk);
    chk("tx masked", 1'b0, tx_irq);
    chk("rx masked", 1'b0, rx_irq);
    rd(4'h8);
    wr(4'h0, 32'hC0);
    wr(4'hC, 32'h5A);
    repeat (60) @(posedge aclk);
    rd(4'hC);
    chk("loop byte", 32'h5A, d);
    $display("end of requests");
    wr(4'h0, 32'h60);
    repeat (2) @(posedge aclk);
    chk("idle inverted", 1'b0, shared_tx_pin_out);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(4'h0);
    chk("ctrl one reset", 32'h0, d);
    chk("port drives tx", 1'b0, shared_tx_pin_oe_n);
    rd(4'h4);
    chk("ctrl two reset", 32'h0, d);
    $display("end of reset");
    final_report;
  end
endmodule
`default_nettype wire
